// file: verilog/scsoe_pkg.sv
// Package for the system clock select and oscillator enable block.
// Assumes a 50 MHz mclk and a classic Wishbone register bus.
package scsoe_pkg;
    localparam int CLK_MHZ = 50;
    // Register byte addresses.
    localparam logic [3:0] ADDR_SYS_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_RC_CTRL   = 4'h4;
    localparam logic [3:0] ADDR_XTAL_CTRL = 4'h8;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'hC;
    // Interrupt registers: enable, then write-one-to-clear.
    localparam logic [4:0] ADDR_IRQ_EN    = 5'h10;
    localparam logic [4:0] ADDR_IRQ_CLR   = 5'h14;
    // System clock control fields.
    localparam int SYS_SEL_LSB   = 5;
    localparam int HI_SRC_BIT    = 3;
    localparam int LO_SRC_BIT    = 2;
    localparam int HI_IDLE_BIT   = 1;
    localparam int LO_IDLE_BIT   = 0;
    localparam logic [2:0] SEL_SUB = 3'h7;
    // Internal RC control fields.
    localparam int RC_FREQ_LSB   = 2;
    localparam int STABLE_BIT    = 1;
    localparam int ENABLE_BIT    = 0;
    // Crystal control fields.
    localparam int XTAL_MODE_BIT = 2;
    // Reset values.
    localparam logic [7:0] SYS_CTRL_RST = 8'h00;
    localparam logic       RC_EN_RST    = 1'b1;
    localparam logic       XTAL_EN_RST  = 1'b0;
    // Switch delay: four system periods plus half a target period, in cycles; the top adds one fixed cycle instead, five in all.
    localparam int SWITCH_BASE_CYC = 4;
    // Stabilisation counts.
    localparam int RC_STAB_CYC   = 64;
    localparam int XTAL_STAB_CYC = 256;
    // Low-power state codes.
    typedef enum logic [3:0]
    {
        SCSOE_RUN   = 4'h1,
        SCSOE_IDLE0 = 4'h2,
        SCSOE_IDLE1 = 4'h4,
        SCSOE_IDLE2 = 4'h8
    } scsoe_pwr_t;
    localparam logic [3:0] PWR_SLEEP = 4'h0;
endpackage : scsoe_pkg

// file: verilog/scsoe_stab_timer.sv
// Oscillator stabilisation timer: restarts on a pulse, flags done at expiry.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ns
module scsoe_stab_timer #(
    parameter int COUNT = 64
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic restart,
    output logic      stable
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge mclk)
    begin
        if (reset || !enable || restart)
        begin
            cnt_reg <= W'(COUNT);
            stable  <= 1'b0;
        end
        else if (cnt_reg != '0)
        begin
            cnt_reg <= cnt_reg - W'(1);
            stable  <= 1'b0;
        end
        else
        begin
            stable <= 1'b1;
        end
    end
endmodule : scsoe_stab_timer

// file: verilog/scsoe_top.sv
// System clock select and oscillator enable control with Wishbone registers.
// Assumes Wishbone classic master, synchronous mclk inputs and an external CPU halt.
//
// Overview of operation
// - Select codes 0-6 divide high clock by 1..64; code 7 picks sub clock.
// - Bit 3 picks high source: 0 internal RC, 1 crystal.
// - Bit 2 picks sub source: 0 internal slow RC, 1 slow crystal.
// - Bit 1 keeps high oscillator running during halt when set.
// - Bit 0 keeps low oscillator running during halt when set.
// - A selection change completes after the switching delay.
// - RC frequency field 00/11 4MHz, 01 8MHz, 10 12MHz; applies once stable.
// - RC stable flag clears then sets on enable or frequency change.
// - RC enable bit 0 switches RC on or off; resets to one.
// - Crystal mode write ignored while pins enabled and crystal enabled.
// - Crystal stable flag clears then sets when crystal enabled.
// - Crystal enable bit 0 turns crystal on or off; resets to zero.
// - Halt with both idle bits clear sleeps; others select idle states.
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
module scsoe_top #(
    parameter int RC_STAB   = scsoe_pkg::RC_STAB_CYC,
    parameter int XTAL_STAB = scsoe_pkg::XTAL_STAB_CYC
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        halt_i,
    input  wire logic        wake_i,
    input  wire logic        crystal_pins_enabled,
    output logic [2:0]       sysclk_select,
    output logic             sysclk_is_sub,
    output logic [6:0]       high_div_ratio,
    output logic             high_src_select,
    output logic             low_src_select,
    output logic             switch_busy,
    output logic             high_osc_run,
    output logic             low_osc_run,
    output logic             rc_osc_run,
    output logic [1:0]       rc_freq_active,
    output logic             crystal_osc_run,
    output logic             crystal_drive_mode,
    output logic [3:0]       power_state,
    output logic             irq
);
    logic [7:0] sys_reg;
    logic [1:0] rc_freq_reg;
    logic       rc_en_reg;
    logic       xtal_mode_reg;
    logic       xtal_en_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_en_reg;
    logic [3:0] sw_cnt_reg;
    logic       rc_stable_q;
    logic       xtal_stable_q;
    logic       rc_restart;
    logic       xtal_restart;
    logic       rc_stable_d;
    logic       xtal_stable_d;
    scsoe_pkg::scsoe_pwr_t pwr_reg;

    wire       req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       wr_b0      = req && wb_we_i && wb_sel_i[0];
    wire       wr_sys     = wr_b0 && (wb_adr_i == {1'b0, scsoe_pkg::ADDR_SYS_CTRL});
    wire       wr_rc      = wr_b0 && (wb_adr_i == {1'b0, scsoe_pkg::ADDR_RC_CTRL});
    wire       wr_xtal    = wr_b0 && (wb_adr_i == {1'b0, scsoe_pkg::ADDR_XTAL_CTRL});
    wire       wr_ien     = wr_b0 && (wb_adr_i == scsoe_pkg::ADDR_IRQ_EN);
    wire       wr_iclr    = wr_b0 && (wb_adr_i == scsoe_pkg::ADDR_IRQ_CLR);
    wire [7:0] din        = wb_dat_i[7:0];
    wire [7:0] sys_new    = {din[7:5], 1'b0, din[3:0]};
    wire       sel_change = wr_sys && (sys_new[7:2] != sys_reg[7:2]);
    wire [1:0] rc_new     = din[scsoe_pkg::RC_FREQ_LSB +: 2];
    wire       rc_en_new  = din[scsoe_pkg::ENABLE_BIT];
    wire       xtal_en_new = din[scsoe_pkg::ENABLE_BIT];
    wire       xtal_mode_locked = crystal_pins_enabled && xtal_en_reg;
    wire       rc_rise    = rc_stable_q && !rc_stable_d;
    wire       xtal_rise  = xtal_stable_q && !xtal_stable_d;
    wire       sw_done    = (sw_cnt_reg == 4'h1);

    assign rc_restart   = wr_rc && ((rc_en_new && !rc_en_reg) || (rc_new != rc_freq_reg));
    assign xtal_restart = wr_xtal && xtal_en_new && !xtal_en_reg;

    scsoe_stab_timer #(.COUNT(RC_STAB)) u_rc_timer (
        .mclk    (mclk),
        .reset   (reset),
        .enable  (rc_en_reg),
        .restart (rc_restart),
        .stable  (rc_stable_q)
    );
    scsoe_stab_timer #(.COUNT(XTAL_STAB)) u_xtal_timer (
        .mclk    (mclk),
        .reset   (reset),
        .enable  (xtal_en_reg),
        .restart (xtal_restart),
        .stable  (xtal_stable_q)
    );

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sys_reg       <= scsoe_pkg::SYS_CTRL_RST;
            rc_freq_reg   <= 2'h0;
            rc_en_reg     <= scsoe_pkg::RC_EN_RST;
            xtal_mode_reg <= 1'b0;
            xtal_en_reg   <= scsoe_pkg::XTAL_EN_RST;
            irq_en_reg    <= 3'h0;
            wb_ack_o      <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req;
            if (wr_sys)
            begin
                sys_reg <= sys_new;
            end
            if (wr_rc)
            begin
                rc_freq_reg <= rc_new;
                rc_en_reg   <= rc_en_new;
            end
            if (wr_xtal)
            begin
                xtal_en_reg <= xtal_en_new;
                if (!xtal_mode_locked)
                begin
                    xtal_mode_reg <= din[scsoe_pkg::XTAL_MODE_BIT];
                end
            end
            if (wr_ien)
            begin
                irq_en_reg <= din[2:0];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sw_cnt_reg <= 4'h0;
        end
        else if (sel_change)
        begin
            sw_cnt_reg <= 4'(scsoe_pkg::SWITCH_BASE_CYC + 1);
        end
        else if (sw_cnt_reg != 4'h0)
        begin
            sw_cnt_reg <= sw_cnt_reg - 4'h1;
        end
    end

    // Sticky events; set wins over clear.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            irq_stat_reg  <= 3'h0;
            rc_stable_d   <= 1'b0;
            xtal_stable_d <= 1'b0;
        end
        else
        begin
            rc_stable_d   <= rc_stable_q;
            xtal_stable_d <= xtal_stable_q;
            irq_stat_reg  <= (irq_stat_reg & ~(wr_iclr ? din[2:0] : 3'h0))
                           | {sw_done, xtal_rise, rc_rise};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset || wake_i)
        begin
            pwr_reg <= scsoe_pkg::SCSOE_RUN;
        end
        else if (halt_i && pwr_reg == scsoe_pkg::SCSOE_RUN)
        begin
            unique case ({sys_reg[scsoe_pkg::HI_IDLE_BIT], sys_reg[scsoe_pkg::LO_IDLE_BIT]})
                2'b01: pwr_reg <= scsoe_pkg::SCSOE_IDLE0;
                2'b11: pwr_reg <= scsoe_pkg::SCSOE_IDLE1;
                2'b10: pwr_reg <= scsoe_pkg::SCSOE_IDLE2;
                2'b00: pwr_reg <= scsoe_pkg::scsoe_pwr_t'(scsoe_pkg::PWR_SLEEP);
            endcase
        end
    end

    wire halted = (pwr_reg != scsoe_pkg::SCSOE_RUN);
    wire [7:0] rd_sys  = sys_reg;
    wire [7:0] rd_rc   = {4'h0, rc_freq_reg, rc_stable_q, rc_en_reg};
    wire [7:0] rd_xtal = {5'h00, xtal_mode_reg, xtal_stable_q, xtal_en_reg};
    wire [7:0] rd_data =
        (wb_adr_i == {1'b0, scsoe_pkg::ADDR_SYS_CTRL})  ? rd_sys :
        (wb_adr_i == {1'b0, scsoe_pkg::ADDR_RC_CTRL})   ? rd_rc :
        (wb_adr_i == {1'b0, scsoe_pkg::ADDR_XTAL_CTRL}) ? rd_xtal :
        (wb_adr_i == {1'b0, scsoe_pkg::ADDR_IRQ_STAT})  ? {5'h00, irq_stat_reg} :
        (wb_adr_i == scsoe_pkg::ADDR_IRQ_EN)            ? {5'h00, irq_en_reg} : 8'h00;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_dat_o <= {24'h0, rd_data};
        end
    end

    assign sysclk_select   = sys_reg[scsoe_pkg::SYS_SEL_LSB +: 3];
    assign sysclk_is_sub   = (sysclk_select == scsoe_pkg::SEL_SUB);
    assign high_div_ratio  = sysclk_is_sub ? 7'h00 : 7'(7'h01 << sysclk_select);
    assign high_src_select = sys_reg[scsoe_pkg::HI_SRC_BIT];
    assign low_src_select  = sys_reg[scsoe_pkg::LO_SRC_BIT];
    assign switch_busy     = (sw_cnt_reg != 4'h0);
    assign high_osc_run    = !halted || sys_reg[scsoe_pkg::HI_IDLE_BIT];
    assign low_osc_run     = !halted || sys_reg[scsoe_pkg::LO_IDLE_BIT];
    // RC enable gating.
    // The RC only stops in halt when it is the high source, since the crystal
    // path may still need it otherwise.
    assign rc_osc_run      = rc_en_reg && (high_src_select || high_osc_run);
    assign crystal_osc_run = xtal_en_reg && (high_src_select ? high_osc_run : 1'b1);
    assign crystal_drive_mode = xtal_mode_reg;
    assign power_state     = pwr_reg;
    assign irq             = |(irq_stat_reg & irq_en_reg);

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rc_freq_active <= 2'h0;
        end
        else if (rc_stable_q)
        begin
            rc_freq_active <= rc_freq_reg;
        end
    end
endmodule : scsoe_top

// file: bench/scsoe_checker.sv
// Port checker for scsoe_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module scsoe_checker (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic       wb_ack_o,
    input wire logic [2:0] sysclk_select,
    input wire logic       sysclk_is_sub,
    input wire logic [6:0] high_div_ratio,
    input wire logic       switch_busy,
    input wire logic       high_osc_run,
    input wire logic       low_osc_run,
    input wire logic       crystal_pins_enabled,
    input wire logic       crystal_osc_run,
    input wire logic       crystal_drive_mode,
    input wire logic [3:0] power_state,
    input wire logic       irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire xwr  = take && wb_we_i && wb_adr_i == 5'h08;
    property p_ack;
        take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack not a single cycle");
    property p_sub;
        sysclk_select == 3'h7 |-> sysclk_is_sub && high_div_ratio == 7'h00;
    endproperty
    a_sub: assert property (p_sub)
        else $error("sub clock select wrong");
    property p_div;
        sysclk_select != 3'h7 |-> !sysclk_is_sub && high_div_ratio == (7'h01 << sysclk_select);
    endproperty
    a_div: assert property (p_div)
        else $error("divide ratio wrong");
    property p_busy;
        $rose(switch_busy) |-> switch_busy [*5] ##1 !switch_busy;
    endproperty
    a_busy: assert property (p_busy)
        else $error("switch delay length wrong");
    property p_sleep;
        power_state == 4'h0 |-> !high_osc_run && !low_osc_run;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("oscillator runs in sleep");
    property p_idle0;
        power_state == 4'h2 |-> !high_osc_run && low_osc_run;
    endproperty
    a_idle0: assert property (p_idle0)
        else $error("idle0 oscillators wrong");
    property p_idle1;
        power_state == 4'h4 |-> high_osc_run && low_osc_run;
    endproperty
    a_idle1: assert property (p_idle1)
        else $error("idle1 oscillators wrong");
    property p_xmode;
        xwr && crystal_pins_enabled && crystal_osc_run |=> $stable(crystal_drive_mode);
    endproperty
    a_xmode: assert property (p_xmode)
        else $error("locked drive mode changed");
    property p_rst;
        $fell(reset) |-> power_state == 4'h1 && !irq && !crystal_osc_run;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset state wrong");
endmodule : scsoe_checker

// file: bench/scsoe_bench.sv
// Self-checking bench for scsoe_top over Wishbone.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ns
module scsoe_bench;
    logic        mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, halt_i, wake_i, irq;
    logic        crystal_pins_enabled, wb_ack_o, sysclk_is_sub, high_src_select;
    logic        low_src_select, switch_busy, high_osc_run, low_osc_run, rc_osc_run;
    logic        crystal_osc_run, crystal_drive_mode;
    logic [4:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, power_state, r;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [2:0]  sysclk_select;
    logic [6:0]  high_div_ratio;
    logic [1:0]  rc_freq_active, f;
    logic [7:0]  q;
    integer      seed = 32'h1a92;
    integer      rnd;
    int          mismatches = 0;
    int          cmp_count = 0;
    // Short stabilisation counts keep the run brief.
    scsoe_top #(.RC_STAB(6), .XTAL_STAB(8)) i_scsoe_top (
        .mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .halt_i, .wake_i, .crystal_pins_enabled,
        .sysclk_select, .sysclk_is_sub, .high_div_ratio, .high_src_select,
        .low_src_select, .switch_busy, .high_osc_run, .low_osc_run, .rc_osc_run,
        .rc_freq_active, .crystal_osc_run, .crystal_drive_mode, .power_state, .irq
    );
    initial
    begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end
    function logic [6:0] div_exp(input logic [2:0] c);
        return (c == 3'h7) ? 7'h00 : 7'h01 << c;
    endfunction : div_exp
    function logic [3:0] pwr_exp(input logic [1:0] i);
        return (i == 2'h0) ? 4'h0 : (i == 2'h1) ? 4'h2 : (i == 2'h2) ? 4'h8 : 4'h4;
    endfunction : pwr_exp
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        do
        begin
            @(posedge mclk);
        end
        while (wb_ack_o !== 1'h1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : bus
    task rdc(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
        bus(1'h0, a, 8'h00);
        chk(q & m, e);
    endtask : rdc
    task wait_sw;
        while (switch_busy === 1'h1)
        begin
            @(posedge mclk);
        end
        @(negedge mclk);
    endtask : wait_sw
    task finish_test;
        $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        finish_test;
    end
    initial
    begin
        {reset, crystal_pins_enabled, wb_sel_i} = 6'h3F;
        {wb_cyc_i, wb_stb_i, wb_we_i, halt_i, wake_i, wb_adr_i, wb_dat_i} = '0;
        repeat (5) @(posedge mclk);
        reset <= 1'h0;
        rdc(5'h00, 8'hFF, 8'h00); // reset value
        rdc(5'h04, 8'hFD, 8'h01); // reset value
        rdc(5'h08, 8'hFF, 8'h00); // reset value
        rdc(5'h18, 8'hFF, 8'h00);
        repeat (10) @(posedge mclk);
        rdc(5'h04, 8'hFF, 8'h03); // stable after reset
        for (int c = 0; c < 8; c++)
        begin
            rnd = $random(seed);
            r = rnd[3:0];
            bus(1'h1, 5'h00, {c[2:0], 1'h0, r});
            wait_sw; // wait out switch
            chk({1'h0, high_div_ratio}, {1'h0, div_exp(c[2:0])}); // ratio
            chk({6'h00, high_src_select, low_src_select}, {6'h00, r[3:2]});
            rdc(5'h00, 8'hFF, {c[2:0], 1'h0, r}); // readback
        end
        chk({7'h00, irq}, 8'h00); // masked event
        bus(1'h1, 5'h10, 8'h04);
        rdc(5'h0C, 8'h04, 8'h04);
        chk({7'h00, irq}, 8'h01); // enabled event
        bus(1'h1, 5'h14, 8'h04);
        rdc(5'h0C, 8'h04, 8'h00);
        chk({7'h00, irq}, 8'h00); // cleared event
        for (int k = 1; k < 5; k++)
        begin
            f = k[1:0];
            bus(1'h1, 5'h04, {4'h0, f, 2'h1});
            rdc(5'h04, 8'hFF, {4'h0, f, 2'h1}); // flag clears
            repeat (12) @(posedge mclk);
            rdc(5'h04, 8'hFF, {4'h0, f, 2'h3}); // flag sets
            chk({6'h00, rc_freq_active}, {6'h00, f}); // code applied
        end
        bus(1'h1, 5'h04, 8'h00);
        rdc(5'h04, 8'hFF, 8'h00); // disabled
        chk({7'h00, rc_osc_run}, 8'h00); // stopped
        bus(1'h1, 5'h04, 8'h01); // field kept at configured code
        bus(1'h1, 5'h08, 8'h04); // mode set before enable
        chk({7'h00, crystal_drive_mode}, 8'h01); // strong drive
        bus(1'h1, 5'h08, 8'h05);
        rdc(5'h08, 8'hFF, 8'h05); // flag clears
        repeat (12) @(posedge mclk);
        rdc(5'h08, 8'hFF, 8'h07); // flag sets
        bus(1'h1, 5'h08, 8'h01);
        rdc(5'h08, 8'hFD, 8'h05); // write refused
        crystal_pins_enabled <= 1'h0;
        bus(1'h1, 5'h08, 8'h01);
        rdc(5'h08, 8'hFD, 8'h01); // write allowed
        for (int i = 0; i < 4; i++)
        begin
            bus(1'h1, 5'h00, {6'h00, i[1:0]});
            wait_sw;
            @(posedge mclk);
            halt_i <= 1'h1;
            @(posedge mclk);
            halt_i <= 1'h0;
            @(negedge mclk);
            chk({4'h0, power_state}, {4'h0, pwr_exp(i[1:0])}); // halt state
            chk({7'h00, rc_osc_run}, {7'h00, i[1]}); // RC source gated
            @(posedge mclk);
            wake_i <= 1'h1;
            @(posedge mclk);
            wake_i <= 1'h0;
            @(negedge mclk);
            chk({4'h0, power_state}, 8'h01); // back to run
        end
        finish_test;
    end
endmodule : scsoe_bench
bind scsoe_top scsoe_checker i_scsoe_checker (
    .mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
    .sysclk_select, .sysclk_is_sub, .high_div_ratio, .switch_busy, .high_osc_run,
    .low_osc_run, .crystal_pins_enabled, .crystal_osc_run, .crystal_drive_mode,
    .power_state, .irq
);
